// ===== include/fbsr_cfg.svh
/*
 constants for the four-stage shift register: width, fifo depth,
 reset values. assumes inclusion by bare name from the design files.
*/
`ifndef FBSR_CFG_SVH
`define FBSR_CFG_SVH
// -------------------------------------------------------------------
// sizes and reset values
// -------------------------------------------------------------------
`define FBSR_STAGES 4
`define FBSR_FIFO_DEPTH 4
`define FBSR_STAGE_RESET 4'h0
`endif

// ===== include/fbsr_pkg.sv
/*
 types for the four-stage shift register.
 assumes nothing of its surroundings.
*/
package fbsr_pkg;
    // which operation a sampled clock edge performs
    typedef enum logic [1:0] {
        FBSR_IDLE,
        FBSR_LOAD,
        FBSR_SHIFT
    } fbsr_op_type;
endpackage : fbsr_pkg

// ===== src/fbsr_fifo.sv
/*
 small fifo with valid/ready on both sides, parameterised width and
 depth. assumes one clock and a synchronous-release reset.
*/
module fbsr_fifo
    import fbsr_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // refuse sizes the wrap-bit pointers cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_size
        $error("fifo depth must be a power of two, at least 2");
    end
    // -------------------------------------------------------------------
    // storage and pointers
    // -------------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];  // word store
    logic [AW:0] wrPtr;  // write pointer with wrap bit
    logic [AW:0] rdPtr;  // read pointer with wrap bit
    logic [AW:0] next_wrPtr;
    logic [AW:0] next_rdPtr;
    logic doWrite;
    logic doRead;
    // full when pointers differ only in wrap bit
    assign inReady = !((wrPtr[AW] != rdPtr[AW]) &&
                       (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
    assign outValid = (wrPtr != rdPtr);
    assign outData = mem[rdPtr[AW-1:0]];
    // next pointer values
    always_comb begin
        doWrite = inValid && inReady;
        doRead = outValid && outReady;
        next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
    end
    // register pointers and store word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
    end
    always_ff @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule : fbsr_fifo

// ===== src/fbsr_shift_reg.sv
/*
 four-stage parallel-access shift register with load, right shift and
 left shift by external feedback. two clocks acting on falling edges,
 sampled as ordinary synchronous inputs; the fifo buffers outputs.
 every operation that finds room queues a snapshot; an operation that finds the fifo
 full still acts on the stages and raises a sticky flag.
 assumes every input but arst_n is synchronous to clock.
*/
// How it works
// RULE1: four stages, serial, parallel, mode, two clocks
// RULE2: mode high selects parallel load
// RULE3: load parallel inputs on left clock fall
// RULE4: serial input ignored while loading
// RULE5: mode low shifts right on right fall
// RULE6: first stage takes serial, others shift on
// RULE7: left shift equals load with mode high
// RULE8: outside wires outputs back for left shift
// RULE9: outside may tie both clocks together
// RULE10: outside changes mode with clocks low
// RULE11: mode changes alone never alter stages
// RULE12: unselected clock edges are ignored
`include "fbsr_cfg.svh"
module fbsr_shift_reg
    import fbsr_pkg::*;
#(
    parameter int STAGES = `FBSR_STAGES,
    parameter int FIFO_DEPTH = `FBSR_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic serial_in,
    input wire logic [STAGES-1:0] parallelIn,
    input wire logic modeSelect,
    input wire logic rightClock,
    input wire logic leftClock,
    output logic [STAGES-1:0] stageOut,
    output logic first_stage_output,
    output logic last_stage_output,
    output logic snapValid,
    input wire logic snapReady,
    output logic [STAGES-1:0] snapData,
    output logic snapOverflow
);
    // the slices below are written for exactly four stages
    if (STAGES != `FBSR_STAGES || FIFO_DEPTH < 2) begin : g_bad_size
        $error("stage count must be four, fifo depth at least two");
    end
    // -------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------
    logic rstMeta;  // first release flop
    logic rst_n;  // released reset copy
    // assertion reaches every flop at once; release is retimed here
    // so no flop leaves reset a cycle before its neighbour
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rst_n <= rstMeta;
        end
    end
    // -------------------------------------------------------------------
    // edge detection and operation select
    // -------------------------------------------------------------------
    logic rightPrev;  // previous right clock level
    logic leftPrev;  // previous left clock level
    logic rightFall;
    logic leftFall;
    fbsr_op_type op;
    // history resets low, the idle level of both clock pins, so no
    // false fall follows reset; a fall is a high sample then a low one
    assign rightFall = rightPrev && !rightClock;
    assign leftFall = leftPrev && !leftClock;
    // choose operation from mode and selected clock only
    always_comb begin
        if (modeSelect && leftFall) begin
            op = FBSR_LOAD;  // [RULE2] [RULE3] [RULE7] [RULE12]
        end else if (!modeSelect && rightFall) begin
            op = FBSR_SHIFT;  // [RULE5] [RULE12]
        end else begin
            op = FBSR_IDLE;  // mode edges alone hold [RULE11]
        end
    end
    // -------------------------------------------------------------------
    // stage storage
    // -------------------------------------------------------------------
    logic [STAGES-1:0] stages;  // bit 0 is first stage
    logic [STAGES-1:0] next_stages;
    logic fifoReady;
    logic next_overflow;
    // next stage word from the chosen operation; a snapshot that
    // cannot enter the fifo leaves the sticky flag set
    always_comb begin
        next_stages = stages;
        next_overflow = snapOverflow;
        case (op)
            FBSR_LOAD: begin
                next_stages = parallelIn;  // serial unused [RULE4] [RULE1]
            end
            FBSR_SHIFT: begin
                // first takes serial, rest move on [RULE6]
                next_stages = {stages[STAGES-2:0], serial_in};
            end
            default: begin
                next_stages = stages;  // [RULE11]
            end
        endcase
        if (op != FBSR_IDLE && !fifoReady) begin
            next_overflow = 1'b1;  // snapshot dropped, sticky
        end
    end
    // register stages, clock history and the overflow flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stages <= `FBSR_STAGE_RESET;
            rightPrev <= 1'b0;
            leftPrev <= 1'b0;
            snapOverflow <= 1'b0;
        end else begin
            stages <= next_stages;
            rightPrev <= rightClock;
            leftPrev <= leftClock;
            snapOverflow <= next_overflow;
        end
    end
    // outputs straight from the stage flops
    assign stageOut = stages;
    assign first_stage_output = stages[0];
    assign last_stage_output = stages[STAGES-1];
    // -------------------------------------------------------------------
    // snapshot fifo of each new stage value
    // -------------------------------------------------------------------
    // the word written is the value the stages take at this edge,
    // so a snapshot always matches what stageOut shows next cycle
    fbsr_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(op != FBSR_IDLE),
        .inReady(fifoReady),
        .inData(next_stages),
        .outValid(snapValid),
        .outReady(snapReady),
        .outData(snapData)
    );
    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    // a left fall in load mode captures the whole parallel word
    a_load_captures: assert property ( // [RULE3]
        @(posedge clock) disable iff (!rst_n)
        (modeSelect && leftFall) |=> stages == $past(parallelIn))
        else $error("load did not capture parallel inputs");
    // serial level set against the first parallel bit, so a leak
    // into the first stage would show
    a_load_ignores_serial: assert property ( // [RULE4]
        @(posedge clock) disable iff (!rst_n)
        (modeSelect && leftFall && serial_in != parallelIn[0]) |=>
        stages[0] == $past(parallelIn[0]))
        else $error("serial leaked into load");
    // right shift moves every stage one place toward the last
    a_shift_moves: assert property ( // [RULE6]
        @(posedge clock) disable iff (!rst_n)
        (!modeSelect && rightFall) |=> stages[3:1] == $past(stages[2:0])
        && stages[0] == $past(serial_in))
        else $error("right shift wrong");
    // a high serial level reaches the first output after one shift
    a_shift_first_serial: assert property ( // [RULE5]
        @(posedge clock) disable iff (!rst_n)
        (!modeSelect && rightFall && serial_in) |=> first_stage_output)
        else $error("first stage missed serial");
    // no selected fall, no change
    a_idle_holds: assert property ( // [RULE12]
        @(posedge clock) disable iff (!rst_n)
        !(modeSelect && leftFall) && !(!modeSelect && rightFall) |=>
        $stable(stages))
        else $error("stages changed without selected edge");
    // mode change with both clocks low, now and one sample back
    a_mode_edge_holds: assert property ( // [RULE11]
        @(posedge clock) disable iff (!rst_n)
        ($changed(modeSelect) && !leftClock && !rightClock &&
        !leftPrev && !rightPrev) |=> $stable(stages))
        else $error("mode change altered stages");
    // mode rising while either clock stands high leaves stages alone
    a_mode_rise_holds: assert property ( // [RULE11]
        @(posedge clock) disable iff (!rst_n)
        ($rose(modeSelect) && (leftClock || rightClock)) |=>
        $stable(stages))
        else $error("mode rise with a clock high altered stages");
    // fed-back outputs make the load a shift toward the first stage
    a_left_shift_form: assert property ( // [RULE7]
        @(posedge clock) disable iff (!rst_n)
        (modeSelect && leftFall && parallelIn[2:0] == stages[3:1]) |=>
        stages[2:0] == $past(stages[3:1]))
        else $error("left shift form wrong");
    // end outputs follow the stages through a right shift
    a_ends_match: assert property ( // [RULE1]
        @(posedge clock) disable iff (!rst_n)
        (!modeSelect && rightFall) |=>
        last_stage_output == $past(stages[2]) &&
        first_stage_output == $past(serial_in))
        else $error("end outputs disagree with stages");
    // right clock falls are ignored in load mode
    a_mode_high_load: assert property ( // [RULE2]
        @(posedge clock) disable iff (!rst_n)
        (modeSelect && rightFall && !leftFall) |=> $stable(stages))
        else $error("right clock acted in load mode");
    // an accepted load leaves a snapshot waiting
    a_op_snapshot: assert property ( // [RULE3]
        @(posedge clock) disable iff (!rst_n)
        (modeSelect && leftFall && fifoReady) |=> snapValid)
        else $error("load left no snapshot");
    // an operation against a full fifo raises the sticky flag
    a_drop_flags: assert property (
        @(posedge clock) disable iff (!rst_n)
        ((modeSelect && leftFall) || (!modeSelect && rightFall)) &&
        !fifoReady |=> snapOverflow)
        else $error("dropped snapshot not flagged");
endmodule : fbsr_shift_reg

// ===== testbench/fbsr_far_logic.sv
/*
 far-side logic: left-shift feedback wiring and a snapshot consumer.
 assumes stageOut changes just after the rising edge of clock.
*/
module fbsr_far_logic (
    input wire logic clock,
    input wire logic stallIn,
    input wire logic leftMode,
    input wire logic serialData,
    input wire logic [3:0] rawParallel,
    input wire logic [3:0] stageOut,
    output logic [3:0] parallelIn,
    output logic snapReady
);
    timeunit 1ns;
    timeprecision 1ns;
    // outputs two..four fed back one place down, serial on the fourth
    assign parallelIn = leftMode ? {serialData, stageOut[3:1]}
                                 : rawParallel;
    // consumer registers its stall, so ready moves after the edge
    always_ff @(posedge clock) begin
        snapReady <= !stallIn;
    end
endmodule : fbsr_far_logic

// ===== testbench/fbsr_shift_reg_test.sv
/*
 self-checking bench for the four-stage shift register.
 assumes the design samples its inputs on the rising edge of clock.
*/
module fbsr_shift_reg_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, arstN = 1'b0, serialIn = 1'b0, modeSelect = 1'b0;
    logic rightClock = 1'b0, leftClock = 1'b0, stallIn = 1'b0;
    logic leftMode = 1'b0, holdStall = 1'b0, snapReady, snapValid;
    logic firstOut, lastOut, snapOverflow;
    logic [3:0] rawParallel = 4'h0, parallelIn, stageOut, snapData;
    logic [3:0] expStage = 4'h0;
    logic [3:0] expQ[$];
    logic [3:0] snapWord = 4'h0;
    logic poppedLast = 1'b0, expOverflow = 1'b0;
    int snapSeq = 0, seenSeq = 0;
    logic [31:0] seed = 32'h7351_7645, r;
    int nErrors = 0, nTests = 0, cycles = 0;
    always #10 clock = ~clock;
    fbsr_shift_reg dut (.clock(clock), .arst_n(arstN),
        .serial_in(serialIn), .parallelIn(parallelIn),
        .modeSelect(modeSelect), .rightClock(rightClock),
        .leftClock(leftClock), .stageOut(stageOut),
        .first_stage_output(firstOut), .last_stage_output(lastOut),
        .snapValid(snapValid), .snapReady(snapReady),
        .snapData(snapData), .snapOverflow(snapOverflow));
    fbsr_far_logic far (.clock(clock), .stallIn(stallIn),
        .leftMode(leftMode), .serialData(serialIn),
        .rawParallel(rawParallel), .stageOut(stageOut),
        .parallelIn(parallelIn), .snapReady(snapReady));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // expected stages after one clock step
    function automatic logic [3:0] nextStage(input logic [3:0] q,
        input logic m, lc, rc, s, input logic [3:0] p);
        if (m && lc) return p; // serial unused on load
        if (!m && rc) return {q[2:0], s}; // first takes serial
        return q; // unselected clock does nothing
    endfunction : nextStage
    task automatic check(input string what, input logic [3:0] e,
        input logic [3:0] g);
        nTests++;
        if (g !== e) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stopTest
    // one step: mode first, then clocks high, then clocks low
    task automatic op(input logic m, lc, rc, s, lsh,
        input logic [3:0] p);
        logic [3:0] par;
        @(negedge clock);
        modeSelect = m; // both clocks low here
        @(negedge clock);
        r = xs();
        stallIn = holdStall | (r[2:0] == 3'h0);
        leftClock = lc;
        rightClock = rc;
        serialIn = s;
        rawParallel = p;
        leftMode = lsh;
        @(negedge clock);
        leftClock = 1'b0;
        rightClock = 1'b0;
        par = lsh ? {s, expStage[3:1]} : p;
        expStage = nextStage(expStage, m, lc, rc, s, par);
        // hand the word to the snapshot model, seen at the next fall
        if (m ? lc : rc) begin
            snapWord <= expStage;
            snapSeq <= snapSeq + 1;
        end
        @(negedge clock);
        check("stageOut", expStage, stageOut);
        check("first_stage_output", {3'h0, expStage[0]},
            {3'h0, firstOut});
        check("last_stage_output", {3'h0, expStage[3]},
            {3'h0, lastOut});
    endtask : op
    // snapshot pops judged where ready and valid are settled
    // a write lands against the occupancy before the pop judged at
    // the previous fall, so that pop is added back in
    always @(negedge clock) begin
        if (snapSeq != seenSeq) begin
            seenSeq = snapSeq;
            if (expQ.size() + int'(poppedLast) < 4) begin
                expQ.push_back(snapWord);
            end else begin
                expOverflow = 1'b1;
            end
        end
        poppedLast = 1'b0;
        if (snapValid === 1'b1 && snapReady === 1'b1) begin
            poppedLast = 1'b1;
            if (expQ.size() == 0) begin
                check("snapCount", 4'h1, 4'h0);
            end else begin
                check("snapData", expQ.pop_front(), snapData);
            end
        end
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            nErrors++;
            $display("timeout reached");
            stopTest();
        end
    end
    initial begin
        repeat (16) @(negedge clock);
        arstN = 1'b1;
        repeat (4) @(negedge clock);
        op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'ha);
        op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
        op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
        op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h5);
        op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hf);
        op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h3);
        op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hc);
        // mode rises while the right clock stands high, then that
        // clock falls in load mode: nothing may move
        @(negedge clock);
        rightClock = 1'b1;
        @(negedge clock);
        modeSelect = 1'b1;
        @(negedge clock);
        rightClock = 1'b0;
        repeat (2) @(negedge clock);
        check("modeRiseHold", expStage, stageOut);
        $display("corner cases done");
        repeat (150) begin
            r = xs();
            op(r[0], r[1], r[2], r[3], r[4], r[8:5]);
        end
        $display("random steps done");
        repeat (8) @(negedge clock);
        check("snapOverflow", {3'h0, expOverflow}, {3'h0, snapOverflow});
        holdStall = 1'b1;
        repeat (6) op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
        check("snapOverflow", 4'h1, {3'h0, snapOverflow});
        holdStall = 1'b0;
        stallIn = 1'b0;
        repeat (10) @(negedge clock);
        check("snapValid", 4'h0, {3'h0, snapValid});
        check("snapLeft", 4'h0, 4'(expQ.size()));
        $display("fifo fill and drain done");
        stopTest();
    end
endmodule : fbsr_shift_reg_test
